// ==== motion_halt_move.v ====
// Motion command block: halts, moves, offset-after-halt, driver enable.
// Assumes an AHB-Lite master; serial framing lives outside and writes the
// command register, reading the acknowledge register for the reply byte.
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_defs.vh"
// Function
// - Gentle halt ramps speed down at programmed deceleration.
// - Gentle halt in a program stops motor only; program keeps running.
// - Driver enable written 1 pulls output low; 0 releases it.
// - Driver enable is inactive after reset.
// - Writing 0 removes driver current and holding torque.
// - Writing absolute target starts move to signed 32-bit position.
// - Each accepted move command is acknowledged with character Y.
// - Global target is stored; move starts only on global execute.
// - Global execute is accepted regardless of unit address.
// - Relative move of signed count moves that many pulses.
// - Direction-only relative move runs until gentle or hard halt.
// - Configured stop input can also stop a relative move.
// - Fast-stop enable makes user input two a soft-halt source.
// - Position counter updates live during relative motion.
// - Armed offset makes soft halt continue at speed for offset distance.
// - After offset covered, decelerate at programmed rate to rest.
// - Serial halt, program halt and stop input are all soft halts.
// - Abrupt stop halts like hard halt but program keeps running.
// - Unit identifier is fixed on query; writes have no effect.
module motion_halt_move (
   input  wire        core_clk,
   input  wire        srst,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        user_input_two,
   input  wire        stop_input,
   output reg         step_pulse,
   output reg         step_dir,
   output reg         driver_enable_n,
   output reg         program_stop
);
   // Motion states, one-hot
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_RUN  = 4'b0010;
   localparam [3:0] ST_OFFS = 4'b0100;
   localparam [3:0] ST_DECL = 4'b1000;

   reg [3:0]  state_reg;
   reg [31:0] position_counter_reg;
   reg [31:0] remain_reg;
   reg        cont_reg;
   reg [31:0] offset_after_halt_reg;
   reg [31:0] global_target_reg;
   reg [31:0] period_base_reg;
   reg [31:0] decel_reg;
   reg [31:0] period_reg;
   reg [31:0] tick_reg;
   reg [5:0]  cfg_reg;
   reg [7:0]  ack_reg;
   reg        ack_valid_reg;
   reg        wr_pend_reg;
   reg        rd_pend_reg;
   reg [11:0] addr_reg;
   reg        in2_s1_reg;
   reg        in2_s2_reg;
   reg        stp_s1_reg;
   reg        stp_s2_reg;

   wire        addr_ok   = hsel & hready & htrans[1];
   wire        cmd_wr    = wr_pend_reg & (addr_reg == `OFS_COMMAND);
   wire        hard_cmd  = cmd_wr & (hwdata[`CMD_HARD_HALT] | hwdata[`CMD_ABRUPT_STOP]);
   wire        gentle_cmd = cmd_wr & hwdata[`CMD_GENTLE_HALT];
   // Stop input and fast stop only count as soft halts in ST_RUN, not during offset or ramp
   wire        stop_src  = (cfg_reg[`CFG_STOP_SETUP] &
                            (stp_s2_reg == cfg_reg[`CFG_STOP_LEVEL])) |
                           (cfg_reg[`CFG_FAST_STOP] & in2_s2_reg);
   wire        soft_halt = gentle_cmd | (stop_src & (state_reg == ST_RUN));
   wire        tgt_wr    = wr_pend_reg & (addr_reg == `OFS_TARGET);
   wire        rel_wr    = wr_pend_reg & (addr_reg == `OFS_REL_COUNT);
   wire        gexec     = cmd_wr & hwdata[`CMD_GLOBAL_EXEC];
   wire        cont_p    = cmd_wr & hwdata[`CMD_CONT_PLUS];
   wire        cont_m    = cmd_wr & hwdata[`CMD_CONT_MINUS];
   wire        pulse_due = (tick_reg == 32'h00000000);
   wire [31:0] abs_delta = hwdata - position_counter_reg;
   wire [31:0] gbl_delta = global_target_reg - position_counter_reg;
   wire [31:0] dist_in   = (tgt_wr | ~rel_wr) ? (tgt_wr ? abs_delta : gbl_delta) : hwdata;
   wire        start_mv  = tgt_wr | rel_wr | gexec | cont_p | cont_m;
   wire [31:0] mag       = dist_in[31] ? (32'h00000000 - dist_in) : dist_in;

   // Input synchronisers; first stage feeds only the second
   always @(posedge core_clk) begin
      if (srst) begin
         in2_s1_reg <= 1'b0;
         in2_s2_reg <= 1'b0;
         stp_s1_reg <= 1'b0;
         stp_s2_reg <= 1'b0;
      end else begin
         in2_s1_reg <= user_input_two;
         in2_s2_reg <= in2_s1_reg;
         stp_s1_reg <= stop_input;
         stp_s2_reg <= stp_s1_reg;
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY
   always @(posedge core_clk) begin
      if (srst) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 12'h000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         wr_pend_reg <= addr_ok & hwrite;
         rd_pend_reg <= addr_ok & ~hwrite;
         if (addr_ok) begin
            addr_reg <= haddr[11:0];
         end
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Read mux, registered so data is ready in the data phase
   always @(posedge core_clk) begin
      if (srst) begin
         hrdata <= 32'h00000000;
      end else if (addr_ok & ~hwrite) begin
         case (haddr[11:0])
            `OFS_TARGET:      hrdata <= step_dir ? position_counter_reg - remain_reg :
                                                   position_counter_reg + remain_reg;
            `OFS_OFFSET_DIST: hrdata <= offset_after_halt_reg;
            `OFS_CONFIG:      hrdata <= {26'h0000000, cfg_reg};
            `OFS_STATUS:      hrdata <= {28'h0000000, state_reg};
            `OFS_POSITION:    hrdata <= position_counter_reg;
            `OFS_UNIT_ID:     hrdata <= {16'h0000, `UNIT_ID_VALUE};
            `OFS_PERIOD:      hrdata <= period_base_reg;
            `OFS_DECEL:       hrdata <= decel_reg;
            `OFS_GLOBAL_TGT:  hrdata <= global_target_reg;
            `OFS_ACK:         hrdata <= {23'h000000, ack_valid_reg, ack_reg};
            default:          hrdata <= 32'h00000000;
         endcase
      end
   end

   // Setting registers; unit identifier has no storage so writes vanish
   always @(posedge core_clk) begin
      if (srst) begin
         cfg_reg               <= 6'h00;
         offset_after_halt_reg <= 32'h00000000;
         global_target_reg     <= 32'h00000000;
         period_base_reg       <= `RST_PERIOD;
         decel_reg             <= `RST_DECEL;
      end else if (wr_pend_reg) begin
         case (addr_reg)
            `OFS_CONFIG:      cfg_reg <= hwdata[5:0];
            `OFS_OFFSET_DIST: offset_after_halt_reg <= hwdata & `OFFSET_MASK;
            `OFS_GLOBAL_TGT:  global_target_reg <= hwdata;
            `OFS_PERIOD:      period_base_reg <= (hwdata < `MIN_PERIOD_SAFE) ?
                                                 `MIN_PERIOD_SAFE : hwdata;
            `OFS_DECEL:       decel_reg <= hwdata;
            default:          cfg_reg <= cfg_reg;
         endcase
      end
   end

   // Acknowledge byte; reading it clears valid, a new accept wins
   always @(posedge core_clk) begin
      if (srst) begin
         ack_reg       <= 8'h00;
         ack_valid_reg <= 1'b0;
      end else if (start_mv) begin
         ack_reg       <= `ACK_CHAR;
         ack_valid_reg <= 1'b1;
      end else if (rd_pend_reg & (addr_reg == `OFS_ACK)) begin
         ack_valid_reg <= 1'b0;
      end
   end

   // Motion state machine with pulse timing and ramp
   always @(posedge core_clk) begin
      if (srst) begin
         state_reg            <= ST_IDLE;
         position_counter_reg <= 32'h00000000;
         remain_reg           <= 32'h00000000;
         cont_reg             <= 1'b0;
         period_reg           <= `RST_PERIOD;
         tick_reg             <= 32'h00000000;
         step_pulse           <= 1'b0;
         step_dir             <= 1'b0;
      end else begin
         step_pulse <= 1'b0;
         if (hard_cmd) begin
            state_reg <= ST_IDLE;
            remain_reg <= 32'h00000000;
            cont_reg   <= 1'b0;
         end else if (start_mv) begin
            state_reg  <= ST_RUN;
            cont_reg   <= cont_p | cont_m;
            remain_reg <= (cont_p | cont_m) ? 32'h00000000 : mag;
            step_dir   <= (cont_p | cont_m) ? cont_m : dist_in[31];
            period_reg <= period_base_reg;
            tick_reg   <= period_base_reg;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  tick_reg <= 32'h00000000;
               end
               ST_RUN, ST_OFFS, ST_DECL: begin
                  if (soft_halt & (state_reg == ST_RUN)) begin
                     if (offset_after_halt_reg != 32'h00000000) begin
                        state_reg  <= ST_OFFS;
                        remain_reg <= offset_after_halt_reg;
                        cont_reg   <= 1'b0;
                     end else begin
                        state_reg <= ST_DECL;
                     end
                  end else if (pulse_due) begin
                     step_pulse <= 1'b1;
                     position_counter_reg <= step_dir ?
                        position_counter_reg - 32'h00000001 :
                        position_counter_reg + 32'h00000001;
                     tick_reg <= period_reg;
                     if (!cont_reg) begin
                        remain_reg <= remain_reg - 32'h00000001;
                     end
                     // Ramp stretches the period; a finite move still ends on count
                     if (state_reg == ST_DECL) begin
                        period_reg <= period_reg + decel_reg;
                        if (period_reg >= `MAX_PERIOD) begin
                           state_reg <= ST_IDLE;
                        end
                     end
                     if (!cont_reg && remain_reg == 32'h00000001) begin
                        state_reg <= (state_reg == ST_OFFS) ? ST_DECL : ST_IDLE;
                        if (state_reg == ST_OFFS) begin
                           remain_reg <= 32'h00000000;
                           cont_reg   <= 1'b1;
                        end
                     end
                  end else begin
                     tick_reg <= tick_reg - 32'h00000001;
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // Outputs: open-collector enable is low when enabled
   always @(posedge core_clk) begin
      if (srst) begin
         driver_enable_n <= 1'b1;
         program_stop    <= 1'b0;
      end else begin
         driver_enable_n <= ~cfg_reg[`CFG_DRV_EN];
         // Gentle halt stops the program only from standby; abrupt stop never
         program_stop <= cmd_wr & ~cfg_reg[`CFG_IN_PROGRAM] &
                         (hwdata[`CMD_GENTLE_HALT] | hwdata[`CMD_HARD_HALT]);
      end
   end
endmodule // motion_halt_move
`default_nettype wire

// ==== motion_cmd_defs.vh ====
// Constants for the motion command block: register offsets, resets, timing.
// Assumes a 100 MHz core clock and word-aligned AHB-Lite register access.
`ifndef MOTION_CMD_DEFS_VH
`define MOTION_CMD_DEFS_VH
`define OFS_COMMAND      12'h000
`define OFS_TARGET       12'h004
`define OFS_REL_COUNT    12'h008
`define OFS_OFFSET_DIST  12'h00C
`define OFS_CONFIG       12'h010
`define OFS_STATUS       12'h014
`define OFS_POSITION     12'h018
`define OFS_UNIT_ID      12'h01C
`define OFS_PERIOD       12'h020
`define OFS_DECEL        12'h024
`define OFS_GLOBAL_TGT   12'h028
`define OFS_ACK          12'h02C
`define CMD_GENTLE_HALT  0
`define CMD_HARD_HALT    1
`define CMD_ABRUPT_STOP  2
`define CMD_ABS_MOVE     3
`define CMD_REL_MOVE     4
`define CMD_CONT_PLUS    5
`define CMD_CONT_MINUS   6
`define CMD_GLOBAL_EXEC  7
`define CFG_DRV_EN       0
`define CFG_FAST_STOP    1
`define CFG_STOP_SETUP   2
`define CFG_STOP_LEVEL   3
`define CFG_IN_PROGRAM   4
`define CFG_SLAVE_SEL    5
`define RST_PERIOD       32'h000003E8
`define RST_DECEL        32'h00000010
`define UNIT_ID_VALUE    16'h1234
`define ACK_CHAR         8'h59
`define MAX_PERIOD       32'h000FFFFF
`define MIN_PERIOD_SAFE  32'h00000002
`define OFFSET_MASK      32'h00FFFFFF
`endif

// ==== step_driver_model.sv ====
// Motor driver model: counts step pulses into a signed position.
// Assumes one-cycle step pulses and a direction level, 1 = reverse.
`timescale 1ns/1ps
`default_nettype none
module step_driver_model (
   input  wire logic               core_clk,
   input  wire logic               srst,
   input  wire logic               step_pulse,
   input  wire logic               step_dir,
   input  wire logic               driver_enable_n,
   output var  logic signed [31:0] steps
);
   // A driver without current cannot move, so its pulses are lost
   always @(posedge core_clk) begin
      if (srst)
         steps <= 32'sh0;
      else if (step_pulse && !driver_enable_n)
         steps <= step_dir ? steps - 1 : steps + 1;
   end
endmodule // step_driver_model
`default_nettype wire

// ==== motion_halt_move_checker.sv ====
// Checker for the motion block: halts, enable and identifier reads.
// Sees only the block's ports; bound from the testbench top.
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_defs.vh"
module motion_halt_move_checker (
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        step_pulse,
   input wire logic        step_dir,
   input wire logic        driver_enable_n,
   input wire logic        program_stop
);
   // A continuous move at the reset period must show a step within this many cycles
   localparam int CONT_LIMIT = 1003;
   logic wcmd, wcfg, inprog;
   logic [15:0] cont_wait;
   wire  ap = hsel && hready && htrans[1];
   // Track the register that the pending data phase writes
   always @(posedge core_clk) begin
      if (srst) begin
         wcmd <= 1'b0;
         wcfg <= 1'b0;
         inprog <= 1'b0;
      end else begin
         wcmd <= ap && hwrite && haddr[11:0] == `OFS_COMMAND;
         wcfg <= ap && hwrite && haddr[11:0] == `OFS_CONFIG;
         if (wcfg)
            inprog <= hwdata[4];
      end
   end
   // Cycles since a continuous plus start with no step yet; any later command disarms, except another continuous plus start, which restarts the count
   always @(posedge core_clk) begin
      if (srst)
         cont_wait <= 16'h0000;
      else if (wcmd && hwdata[5] && !hwdata[1] && !hwdata[2])
         cont_wait <= 16'h0001;
      else if (step_pulse || wcmd)
         cont_wait <= 16'h0000;
      else if (cont_wait != 16'h0000 && cont_wait != 16'hFFFF)
         cont_wait <= cont_wait + 16'h0001;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   // The setting lands at the data-phase edge, the pin one edge later
   property p_drv_on; wcfg && hwdata[0] |=> ##1 !driver_enable_n; endproperty
   a_drv_on: assert property (p_drv_on)
      else $error("driver enable not low after write of one");
   property p_drv_off; wcfg && !hwdata[0] |=> ##1 driver_enable_n; endproperty
   a_drv_off: assert property (p_drv_off)
      else $error("driver enable not released after write of zero");
   property p_rst; $fell(srst) |-> driver_enable_n && !step_pulse; endproperty
   a_rst: assert property (p_rst)
      else $error("driver active after reset");
   // One pulse may already be in flight at the halt edge
   property p_halt; wcmd && (hwdata[1] || hwdata[2]) |=> ##1 !step_pulse [*8]; endproperty
   a_halt: assert property (p_halt)
      else $error("step pulse after hard halt");
   property p_abrupt; wcmd && hwdata[2] && !hwdata[1] |=> !program_stop [*4]; endproperty
   a_abrupt: assert property (p_abrupt)
      else $error("abrupt stop ended the program");
   property p_gentle; wcmd && hwdata[0] && inprog |=> !program_stop [*4]; endproperty
   a_gentle: assert property (p_gentle)
      else $error("gentle halt inside program ended the program");
   property p_uid;
      ap && !hwrite && haddr[11:0] == `OFS_UNIT_ID |=> hrdata == {16'h0000, `UNIT_ID_VALUE};
   endproperty
   a_uid: assert property (p_uid)
      else $error("unit identifier read wrong");
   property p_cont; cont_wait <= CONT_LIMIT; endproperty
   a_cont: assert property (p_cont)
      else $error("continuous move gave no step");
   property p_pstop; wcmd && hwdata[0] && !hwdata[2] && !inprog |=> program_stop; endproperty
   a_pstop: assert property (p_pstop)
      else $error("gentle halt in standby did not stop the program");
   property p_dir; wcmd && hwdata[6] |-> ##[1:3] step_dir; endproperty
   a_dir: assert property (p_dir)
      else $error("reverse move without reverse direction");
endmodule // motion_halt_move_checker
`default_nettype wire

// ==== tb.sv ====
// Testbench for the motion block: AHB-Lite tasks and move scenarios.
// Assumes the lone slave drives hready and a step driver model counts pulses.
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_defs.vh"
module tb;
   logic               core_clk = 1'b0;
   logic               srst = 1'b1;
   logic               hsel = 1'b0;
   logic [31:0]        haddr = 32'h0;
   logic [1:0]         htrans = 2'h0;
   logic               hwrite = 1'b0;
   logic [2:0]         hsize = 3'h2;
   logic [31:0]        hwdata = 32'h0;
   logic               user_input_two = 1'b0;
   logic               stop_input = 1'b0;
   logic [31:0]        r, p;
   wire  [31:0]        hrdata;
   wire                hreadyout, hresp, step_pulse, step_dir, driver_enable_n, program_stop;
   wire  signed [31:0] steps;
   int                 error_cnt = 0;
   int                 tests_run = 0;
   always #5 core_clk = ~core_clk;
   motion_halt_move uut (.core_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .user_input_two, .stop_input,
      .step_pulse, .step_dir, .driver_enable_n, .program_stop);
   step_driver_model drv (.core_clk, .srst, .step_pulse, .step_dir, .driver_enable_n, .steps);
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // Single word transfer; entered just after a rising edge
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // Polls status; the watchdog cuts a move that never ends
   task idle;
      r = 32'h0;
      while (r !== 32'h1) bus(1'b0, `OFS_STATUS, 32'h0);
   endtask
   task pos(input logic [31:0] e);
      bus(1'b0, `OFS_POSITION, 32'h0);
      chk(r, e);
      chk(steps, e);
      chk(hresp, 1'b0);
   endtask
   // Long count move that an input must cut short
   task cut(input logic [31:0] cfg);
      bus(1'b1, `OFS_CONFIG, cfg);
      bus(1'b0, `OFS_POSITION, 32'h0);
      p = r;
      bus(1'b1, `OFS_REL_COUNT, 32'h3E8);
      repeat (30) @(posedge core_clk);
      user_input_two <= cfg[1];
      stop_input <= cfg[2];
      idle;
      bus(1'b0, `OFS_POSITION, 32'h0);
      user_input_two <= 1'b0;
      stop_input <= 1'b0;
   endtask
   task finish_test;
      if (error_cnt == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      error_cnt++;
      finish_test;
   end
   initial begin
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      bus(1'b1, `OFS_UNIT_ID, 32'hFFFF);
      bus(1'b0, `OFS_UNIT_ID, 32'h0);
      chk(r, {16'h0, `UNIT_ID_VALUE});
      chk(driver_enable_n, 1'b1);
      bus(1'b1, `OFS_PERIOD, 32'h4);
      bus(1'b1, `OFS_DECEL, `MAX_PERIOD);
      // Slave select stays zero while the global target is used
      bus(1'b1, `OFS_CONFIG, 32'h11);
      bus(1'b1, `OFS_REL_COUNT, 32'h5);
      chk(driver_enable_n, 1'b0);
      bus(1'b0, `OFS_ACK, 32'h0);
      chk(r, {23'h0, 1'b1, `ACK_CHAR});
      idle;
      pos(32'h5);
      bus(1'b1, `OFS_REL_COUNT, 32'hFFFFFFFD);
      idle;
      pos(32'h2);
      bus(1'b1, `OFS_TARGET, 32'hFFFFFFFC);
      idle;
      pos(32'hFFFFFFFC);
      bus(1'b1, `OFS_GLOBAL_TGT, 32'hA);
      repeat (20) @(posedge core_clk);
      pos(32'hFFFFFFFC);
      bus(1'b1, `OFS_COMMAND, 32'h80);
      idle;
      pos(32'hA);
      bus(1'b1, `OFS_COMMAND, 32'h20);
      repeat (40) @(posedge core_clk);
      bus(1'b0, `OFS_POSITION, 32'h0);
      p = r;
      repeat (20) @(posedge core_clk);
      bus(1'b0, `OFS_POSITION, 32'h0);
      chk($signed(r) > $signed(p), 1'b1);
      bus(1'b1, `OFS_COMMAND, 32'h2);
      bus(1'b0, `OFS_POSITION, 32'h0);
      p = r;
      repeat (20) @(posedge core_clk);
      pos(p);
      bus(1'b1, `OFS_COMMAND, 32'h40);
      repeat (40) @(posedge core_clk);
      bus(1'b1, `OFS_COMMAND, 32'h1);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(r, 32'h8);
      idle;
      bus(1'b1, `OFS_OFFSET_DIST, 32'h6);
      bus(1'b1, `OFS_COMMAND, 32'h20);
      repeat (40) @(posedge core_clk);
      bus(1'b0, `OFS_POSITION, 32'h0);
      p = r;
      bus(1'b1, `OFS_COMMAND, 32'h1);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(r, 32'h4);
      idle;
      bus(1'b0, `OFS_POSITION, 32'h0);
      // Six offset steps, two ramp steps, and at most one step before the halt lands
      chk($signed(r - p) >= 8 && $signed(r - p) <= 9, 1'b1);
      bus(1'b1, `OFS_COMMAND, 32'h40);
      repeat (30) @(posedge core_clk);
      bus(1'b1, `OFS_COMMAND, 32'h4);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(r, 32'h1);
      bus(1'b1, `OFS_OFFSET_DIST, 32'h0);
      cut(32'h3);
      chk($signed(r - p) > 0 && $signed(r - p) < 1000, 1'b1);
      cut(32'hD);
      chk($signed(r - p) > 0 && $signed(r - p) < 1000, 1'b1);
      // Gentle halt from standby: motor ramps down and the program is told to stop
      bus(1'b1, `OFS_CONFIG, 32'h1);
      bus(1'b1, `OFS_COMMAND, 32'h20);
      repeat (20) @(posedge core_clk);
      bus(1'b1, `OFS_COMMAND, 32'h1);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(r, 32'h8);
      idle;
      bus(1'b1, `OFS_CONFIG, 32'h0);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(driver_enable_n, 1'b1);
      finish_test;
   end
endmodule // tb
bind motion_halt_move motion_halt_move_checker chk_i (.core_clk, .srst, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hrdata, .step_pulse, .step_dir, .driver_enable_n,
   .program_stop);
`default_nettype wire
